/* File: verilog/touch_key_counter_config.sv */
// Touch key counter, time slot and oscillator configuration block
`timescale 1ns/100ps

module touch_key_counter_config #(
    parameter int NUM_MOD = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [touch_key_pkg::ADDR_W-1:0] addr,
    input wire logic [touch_key_pkg::DATA_W-1:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    output logic [touch_key_pkg::DATA_W-1:0] rdData_r,
    // Sense oscillator returns, asynchronous
    input wire logic [NUM_MOD-1:0] keyOscIn,
    input wire logic [NUM_MOD-1:0] refOscIn,
    // Oscillator and pad controls
    output logic [1:0] oscFreqSel_r,
    output logic [NUM_MOD-1:0] keyOscRun_r,
    output logic [NUM_MOD-1:0] refOscRun_r,
    output touch_key_pkg::senseCfg_t [NUM_MOD-1:0] senseOut_r,
    output logic [NUM_MOD-1:0][3:0] pinSenseEn_r,
    output logic [NUM_MOD-1:0][9:0] refCapCode_r,
    // Interrupt
    output logic irq_r
);

    // ====================================================================
    // Global state
    logic detectStart_r;
    logic startPrev_r;
    logic running_r;
    logic slotOverflowFlag_r;
    logic [7:0] slotPreload_r;
    logic [15:0] calCount_r;
    logic [touch_key_pkg::IRQ_W-1:0] irqStatus_r;
    logic [touch_key_pkg::IRQ_W-1:0] irqStatus_nxt;
    logic [touch_key_pkg::IRQ_W-1:0] irqEnable_r;
    logic [touch_key_pkg::SYS_DIV_W-1:0] sysDiv_r;
    logic [2:0] hopLfsr_r;
    logic startRise;
    logic sysTick;
    logic slotOverflow;
    logic calWrap;
    logic cfWrapAny;
    logic [touch_key_pkg::DATA_W-1:0] rdData_nxt;

    // Per-module views gathered from the generate loop
    wire [15:0] cfCountW [NUM_MOD];
    wire touch_key_pkg::senseCfg_t senseCfgW [NUM_MOD];
    wire touch_key_pkg::enableCfg_t enableCfgW [NUM_MOD];
    wire [9:0] capCodeW [NUM_MOD];
    wire [NUM_MOD-1:0] keyEdgeW;
    wire [NUM_MOD-1:0] refEdgeW;
    wire [NUM_MOD-1:0] slotOvfW;
    wire [NUM_MOD-1:0] cfWrapW;

    assign startRise = detectStart_r & ~startPrev_r;
    assign sysTick = (sysDiv_r == touch_key_pkg::SYS_DIV_W'(touch_key_pkg::SYS_DIV - 1));
    // Module 0 slot counter governs all modules, so one timeout ends the frame
    assign slotOverflow = running_r & slotOvfW[0];
    assign calWrap = running_r & refEdgeW[0] & (calCount_r == 16'hFFFF);
    assign cfWrapAny = |cfWrapW;

    // ====================================================================
    // Oscillator frequency select
    always_ff @(posedge clk)
    begin
        if (!resetn)
            oscFreqSel_r <= touch_key_pkg::OSC_FREQ_RST;
        else if (wrEn && addr == touch_key_pkg::OFF_OSC_FREQ)
            oscFreqSel_r <= wrData[1:0];
    end

    // ====================================================================
    // Detection start and preload registers
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            detectStart_r <= 1'b0;
            slotPreload_r <= touch_key_pkg::PRELOAD_RST;
        end
        else
        begin
            if (wrEn && addr == touch_key_pkg::OFF_SLOT_CTRL)
                detectStart_r <= wrData[touch_key_pkg::SLOT_START_BIT];
            if (wrEn && addr == touch_key_pkg::OFF_PRELOAD)
                slotPreload_r <= wrData;
        end
    end

    // Edge history for the start bit
    always_ff @(posedge clk)
    begin
        if (!resetn)
            startPrev_r <= 1'b0;
        else
            startPrev_r <= detectStart_r;
    end

    // ====================================================================
    // Measurement run state: on at the start edge, off at timeout or stop
    always_ff @(posedge clk)
    begin
        if (!resetn)
            running_r <= 1'b0;
        else if (!detectStart_r)
            running_r <= 1'b0;
        else if (startRise)
            running_r <= 1'b1;
        else if (slotOverflow)
            running_r <= 1'b0;
    end

    // ====================================================================
    // Overflow flag: software may only clear it; a timeout in the same cycle wins
    always_ff @(posedge clk)
    begin
        if (!resetn)
            slotOverflowFlag_r <= 1'b0;
        else if (slotOverflow)
            slotOverflowFlag_r <= 1'b1;
        else if (wrEn && addr == touch_key_pkg::OFF_SLOT_CTRL
                 && !wrData[touch_key_pkg::SLOT_OVF_BIT])
            slotOverflowFlag_r <= 1'b0;
    end

    // ====================================================================
    // System clock divider feeding slot counters that select fsys/4
    always_ff @(posedge clk)
    begin
        if (!resetn)
            sysDiv_r <= '0;
        else
            sysDiv_r <= sysDiv_r + 1'b1;
    end

    // ====================================================================
    // Calibration counter counts module 0 reference oscillator cycles
    always_ff @(posedge clk)
    begin
        if (!resetn)
            calCount_r <= 16'h0000;
        else if (!detectStart_r)
            calCount_r <= 16'h0000;
        else if (running_r && refEdgeW[0])
            calCount_r <= calCount_r + 16'h0001;
    end

    // ====================================================================
    // Hardware hop sequence steps once per measurement
    always_ff @(posedge clk)
    begin
        if (!resetn)
            hopLfsr_r <= touch_key_pkg::HOP_SEED;
        else if (startRise)
            hopLfsr_r <= {hopLfsr_r[1:0], hopLfsr_r[2] ^ hopLfsr_r[1]};
    end

    // ====================================================================
    // Per-module sensing logic
    for (genvar m = 0; m < NUM_MOD; m++)
    begin : gen_mod
        localparam logic [7:0] BASE = 8'(touch_key_pkg::MOD_BASE
                                         + m * touch_key_pkg::MOD_STRIDE);
        touch_key_pkg::senseCfg_t senseCfg_r;
        touch_key_pkg::enableCfg_t enableCfg_r;
        logic [9:0] capCode_r;
        logic [15:0] cfCount_r;
        logic [1:0] keySync_r;
        logic [1:0] refSync_r;
        logic keyLast_r;
        logic refLast_r;
        logic [touch_key_pkg::UNIT_W-1:0] unitCount_r;
        logic [7:0] slotCount_r;
        logic slotTick;
        logic unitWrap;

        // Two-stage synchronisers; edges are taken from the second stage only
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                keySync_r <= 2'h0;
                refSync_r <= 2'h0;
                keyLast_r <= 1'b0;
                refLast_r <= 1'b0;
            end
            else
            begin
                keySync_r <= {keySync_r[0], keyOscIn[m]};
                refSync_r <= {refSync_r[0], refOscIn[m]};
                keyLast_r <= keySync_r[1];
                refLast_r <= refSync_r[1];
            end
        end
        assign keyEdgeW[m] = keySync_r[1] & ~keyLast_r;
        assign refEdgeW[m] = refSync_r[1] & ~refLast_r;

        // Control and capacitor registers
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                senseCfg_r <= '0;
                enableCfg_r <= '0;
                capCode_r <= 10'h000;
            end
            else if (wrEn)
            begin
                if (addr == BASE + touch_key_pkg::MOFF_SENSE)
                    senseCfg_r <= {wrData[7:5], wrData[3:0]};
                if (addr == BASE + touch_key_pkg::MOFF_ENABLE)
                    enableCfg_r <= {wrData[7], wrData[5:0]};
                if (addr == BASE + touch_key_pkg::MOFF_CAP_LOW)
                    capCode_r[7:0] <= wrData;
                if (addr == BASE + touch_key_pkg::MOFF_CAP_HIGH)
                    capCode_r[9:8] <= wrData[1:0];
            end
        end

        // Slot clock: reference oscillator or divided system clock
        assign slotTick = enableCfg_r.slotClockSel ? sysTick : refEdgeW[m];
        assign unitWrap = slotTick
                          & (unitCount_r == touch_key_pkg::UNIT_W'(touch_key_pkg::UNIT_PERIODS - 1));

        // Unit counter clears with start low; slot counter only reloads at start
        always_ff @(posedge clk)
        begin
            if (!resetn)
                unitCount_r <= '0;
            else if (!detectStart_r)
                unitCount_r <= '0;
            else if (running_r && slotTick)
                unitCount_r <= unitCount_r + 1'b1;
        end

        always_ff @(posedge clk)
        begin
            if (!resetn)
                slotCount_r <= 8'h00;
            else if (startRise)
                slotCount_r <= slotPreload_r;
            else if (running_r && unitWrap)
                slotCount_r <= slotCount_r + 8'h01;
        end
        assign slotOvfW[m] = unitWrap & (slotCount_r == 8'hFF);

        // Capacitance-to-frequency counter on the key oscillator
        always_ff @(posedge clk)
        begin
            if (!resetn)
                cfCount_r <= 16'h0000;
            else if (!detectStart_r)
                cfCount_r <= 16'h0000;
            else if (running_r && keyEdgeW[m])
                cfCount_r <= cfCount_r + 16'h0001;
        end
        assign cfWrapW[m] = running_r & keyEdgeW[m] & (cfCount_r == 16'hFFFF);

        // Analog-facing controls; only the oscillator run enables are gated by the run state
        always_ff @(posedge clk)
        begin
            if (!resetn)
            begin
                keyOscRun_r[m] <= 1'b0;
                refOscRun_r[m] <= 1'b0;
                senseOut_r[m] <= '0;
                pinSenseEn_r[m] <= 4'h0;
                refCapCode_r[m] <= 10'h000;
            end
            else
            begin
                keyOscRun_r[m] <= running_r & ~slotOverflow
                                  & enableCfg_r.keyOscEn;
                refOscRun_r[m] <= running_r & ~slotOverflow
                                  & enableCfg_r.refOscEn;
                senseOut_r[m].keyMuxSel <= senseCfg_r.keyMuxSel;
                senseOut_r[m].freqDoubleEn <= senseCfg_r.freqDoubleEn;
                senseOut_r[m].hopCtrlSource <= senseCfg_r.hopCtrlSource;
                // Hardware hopping overrides the software code
                senseOut_r[m].hopFreqSel <= senseCfg_r.hopCtrlSource
                                            ? hopLfsr_r : senseCfg_r.hopFreqSel;
                pinSenseEn_r[m] <= enableCfg_r.pinSenseEn;
                refCapCode_r[m] <= capCode_r;
            end
        end

        assign cfCountW[m] = cfCount_r;
        assign senseCfgW[m] = senseCfg_r;
        assign enableCfgW[m] = enableCfg_r;
        assign capCodeW[m] = capCode_r;
    end

    // ====================================================================
    // Interrupt status: set wins over a clear in the same cycle
    always_comb
    begin
        irqStatus_nxt = irqStatus_r;
        if (wrEn && addr == touch_key_pkg::OFF_IRQ_CLR)
            irqStatus_nxt = irqStatus_r & ~wrData[touch_key_pkg::IRQ_W-1:0];
        if (slotOverflow)
            irqStatus_nxt[touch_key_pkg::IRQ_SLOT_BIT] = 1'b1;
        if (cfWrapAny)
            irqStatus_nxt[touch_key_pkg::IRQ_CF_BIT] = 1'b1;
        if (calWrap)
            irqStatus_nxt[touch_key_pkg::IRQ_CAL_BIT] = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            irqStatus_r <= '0;
            irqEnable_r <= '0;
        end
        else
        begin
            irqStatus_r <= irqStatus_nxt;
            if (wrEn && addr == touch_key_pkg::OFF_IRQ_EN)
                irqEnable_r <= wrData[touch_key_pkg::IRQ_W-1:0];
        end
    end

    // Level interrupt from enabled sticky bits
    always_ff @(posedge clk)
    begin
        if (!resetn)
            irq_r <= 1'b0;
        else
            irq_r <= |(irqStatus_r & irqEnable_r);
    end

    // ====================================================================
    // Read decode; unimplemented bits and unmapped addresses read zero
    always_comb
    begin
        rdData_nxt = 8'h00;
        case (addr)
            touch_key_pkg::OFF_OSC_FREQ:
                rdData_nxt = {6'h00, oscFreqSel_r};
            touch_key_pkg::OFF_CAL_LOW:
                rdData_nxt = calCount_r[7:0];
            touch_key_pkg::OFF_CAL_HIGH:
                rdData_nxt = calCount_r[15:8];
            touch_key_pkg::OFF_SLOT_CTRL:
                rdData_nxt = {1'b0, slotOverflowFlag_r, detectStart_r, 5'h00};
            touch_key_pkg::OFF_PRELOAD:
                rdData_nxt = slotPreload_r;
            touch_key_pkg::OFF_IRQ_STAT:
                rdData_nxt = 8'(irqStatus_r);
            touch_key_pkg::OFF_IRQ_EN:
                rdData_nxt = 8'(irqEnable_r);
            default:
                rdData_nxt = 8'h00;
        endcase
        for (int m = 0; m < NUM_MOD; m++)
        begin
            if (addr == 8'(touch_key_pkg::MOD_BASE + m * touch_key_pkg::MOD_STRIDE
                           + touch_key_pkg::MOFF_SENSE))
                rdData_nxt = {senseCfgW[m][6:4], 1'b0, senseCfgW[m][3:0]};
            if (addr == 8'(touch_key_pkg::MOD_BASE + m * touch_key_pkg::MOD_STRIDE
                           + touch_key_pkg::MOFF_ENABLE))
                rdData_nxt = {enableCfgW[m][6], 1'b0, enableCfgW[m][5:0]};
            if (addr == 8'(touch_key_pkg::MOD_BASE + m * touch_key_pkg::MOD_STRIDE
                           + touch_key_pkg::MOFF_CAP_LOW))
                rdData_nxt = capCodeW[m][7:0];
            if (addr == 8'(touch_key_pkg::MOD_BASE + m * touch_key_pkg::MOD_STRIDE
                           + touch_key_pkg::MOFF_CAP_HIGH))
                rdData_nxt = {6'h00, capCodeW[m][9:8]};
            if (addr == 8'(touch_key_pkg::MOD_BASE + m * touch_key_pkg::MOD_STRIDE
                           + touch_key_pkg::MOFF_CF_LOW))
                rdData_nxt = cfCountW[m][7:0];
            if (addr == 8'(touch_key_pkg::MOD_BASE + m * touch_key_pkg::MOD_STRIDE
                           + touch_key_pkg::MOFF_CF_HIGH))
                rdData_nxt = cfCountW[m][15:8];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (!resetn)
            rdData_r <= 8'h00;
        else if (rdEn)
            rdData_r <= rdData_nxt;
        else
            rdData_r <= 8'h00;
    end

endmodule

/* File: verilog/touch_key_pkg.sv */
// Package: register map, field layout, reset values and timing for the touch key counter block
package touch_key_pkg;

    // ====================================================================
    // Bus widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ====================================================================
    // Global register offsets
    localparam logic [7:0] OFF_OSC_FREQ = 8'h00;
    localparam logic [7:0] OFF_CAL_LOW = 8'h01;
    localparam logic [7:0] OFF_CAL_HIGH = 8'h02;
    localparam logic [7:0] OFF_SLOT_CTRL = 8'h03;
    localparam logic [7:0] OFF_PRELOAD = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h05;
    localparam logic [7:0] OFF_IRQ_EN = 8'h06;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h07;

    // ====================================================================
    // Per-module register window: base + index * stride + local offset
    localparam logic [7:0] MOD_BASE = 8'h10;
    localparam logic [7:0] MOD_STRIDE = 8'h08;
    localparam logic [7:0] MOFF_SENSE = 8'h00;
    localparam logic [7:0] MOFF_ENABLE = 8'h01;
    localparam logic [7:0] MOFF_CAP_LOW = 8'h02;
    localparam logic [7:0] MOFF_CAP_HIGH = 8'h03;
    localparam logic [7:0] MOFF_CF_LOW = 8'h04;
    localparam logic [7:0] MOFF_CF_HIGH = 8'h05;

    // ====================================================================
    // Field positions
    localparam int SLOT_START_BIT = 5;
    localparam int SLOT_OVF_BIT = 6;
    localparam int IRQ_SLOT_BIT = 0;
    localparam int IRQ_CF_BIT = 1;
    localparam int IRQ_CAL_BIT = 2;
    localparam int IRQ_W = 3;

    // ====================================================================
    // Reset values
    localparam logic [1:0] OSC_FREQ_RST = 2'h3;
    localparam logic [7:0] PRELOAD_RST = 8'h00;
    localparam logic [2:0] HOP_SEED = 3'h1;

    // ====================================================================
    // Timing: time slot is (256 - preload) units of 32 slot clocks
    localparam int UNIT_PERIODS = 32;
    localparam int UNIT_W = $clog2(UNIT_PERIODS);
    localparam int SYS_DIV = 4;
    localparam int SYS_DIV_W = $clog2(SYS_DIV);

    // ====================================================================
    // Field groups of the two per-module control registers
    typedef struct packed {
        logic [1:0] keyMuxSel;
        logic freqDoubleEn;
        logic hopCtrlSource;
        logic [2:0] hopFreqSel;
    } senseCfg_t;

    typedef struct packed {
        logic slotClockSel;
        logic refOscEn;
        logic keyOscEn;
        logic [3:0] pinSenseEn;
    } enableCfg_t;

endpackage

/* File: test/touch_key_props.sv */
// Checker: port-level properties of the touch key counter block
`timescale 1ns/100ps

module touch_key_props #(
    parameter int NUM_MOD = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    input wire logic wrEn,
    input wire logic rdEn,
    input wire logic [7:0] rdData_r,
    // Oscillators and pad controls
    input wire logic [NUM_MOD-1:0] keyOscIn,
    input wire logic [NUM_MOD-1:0] refOscIn,
    input wire logic [1:0] oscFreqSel_r,
    input wire logic [NUM_MOD-1:0] keyOscRun_r,
    input wire logic [NUM_MOD-1:0] refOscRun_r,
    input wire touch_key_pkg::senseCfg_t [NUM_MOD-1:0] senseOut_r,
    input wire logic [NUM_MOD-1:0][3:0] pinSenseEn_r,
    input wire logic [NUM_MOD-1:0][9:0] refCapCode_r,
    // Interrupt
    input wire logic irq_r
);
    // ====================================================================
    // Frequency and module 0 write decode; a quiet cycle after a write lets copies settle
    logic [7:0] wd_r;
    logic wFreq;
    logic wSense;
    logic wEnab;
    logic wCapL;
    logic wCapH;
    assign wFreq = wrEn && addr == touch_key_pkg::OFF_OSC_FREQ;
    assign wSense = wrEn && addr == touch_key_pkg::MOD_BASE;
    assign wEnab = wrEn && addr == touch_key_pkg::MOD_BASE + touch_key_pkg::MOFF_ENABLE;
    assign wCapL = wrEn && addr == touch_key_pkg::MOD_BASE + touch_key_pkg::MOFF_CAP_LOW;
    assign wCapH = wrEn && addr == touch_key_pkg::MOD_BASE + touch_key_pkg::MOFF_CAP_HIGH;

    // Last written byte, kept only on writes
    always_ff @(posedge clk)
        if (wrEn)
            wd_r <= wrData;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ====================================================================
    // Properties
    chk_reset_state:
    assert property ($rose(resetn) |-> oscFreqSel_r == 2'h3 && !irq_r)
        else $error("frequency code or interrupt wrong after reset");
    chk_freq_follow:
    assert property (wFreq ##1 !wrEn |=> oscFreqSel_r == wd_r[1:0])
        else $error("frequency code does not follow write");
    chk_freq_readback:
    assert property (rdEn && addr == touch_key_pkg::OFF_OSC_FREQ |=>
        rdData_r == {6'h00, oscFreqSel_r})
        else $error("frequency register readback wrong");
    chk_sense_bit4:
    assert property (rdEn && addr == touch_key_pkg::MOD_BASE |=> !rdData_r[4])
        else $error("sense control bit 4 reads one");
    chk_cap_low:
    assert property (wCapL ##1 !wrEn |=> refCapCode_r[0][7:0] == wd_r)
        else $error("capacitor code low byte wrong");
    chk_cap_top:
    assert property (wCapH ##1 !wrEn |=> refCapCode_r[0][9:8] == wd_r[1:0])
        else $error("capacitor code top bits wrong");
    chk_pin_enables:
    assert property (wEnab ##1 !wrEn |=> pinSenseEn_r[0] == wd_r[3:0])
        else $error("pin sense enables wrong");
    chk_mux_double:
    assert property (wSense ##1 !wrEn |=> {senseOut_r[0].keyMuxSel,
        senseOut_r[0].freqDoubleEn, senseOut_r[0].hopCtrlSource} == {wd_r[7:5], wd_r[3]})
        else $error("mux, doubling or hop source wrong");
    chk_sw_hop:
    assert property (wSense && !wrData[3] ##1 !wrEn |=> senseOut_r[0].hopFreqSel == wd_r[2:0])
        else $error("software hop code not applied");
    chk_osc_stop:
    assert property ($rose(irq_r) |-> keyOscRun_r == '0 && refOscRun_r == '0)
        else $error("oscillators still run at interrupt");
endmodule

bind touch_key_counter_config touch_key_props #(.NUM_MOD(NUM_MOD)) props (
    .clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData_r(rdData_r), .keyOscIn(keyOscIn), .refOscIn(refOscIn),
    .oscFreqSel_r(oscFreqSel_r), .keyOscRun_r(keyOscRun_r), .refOscRun_r(refOscRun_r),
    .senseOut_r(senseOut_r), .pinSenseEn_r(pinSenseEn_r), .refCapCode_r(refCapCode_r),
    .irq_r(irq_r));

/* File: test/touch_pad_osc.sv */
// Partner model: one touch pad sense oscillator
`timescale 1ns/100ps

module touch_pad_osc #(
    parameter int HALF_NS = 50
) (
    // Run request from the block
    input wire logic run,
    // Oscillator toward the block
    output logic osc
);
    // Toggles only while run; a stopped pad rests low so no stray edge gets counted
    initial osc = 1'b0;
    always
    begin
        #(HALF_NS);
        osc = run ? ~osc : 1'b0;
    end
endmodule

/* File: test/tb.sv */
// Testbench: register and measurement checks of the touch key block
`timescale 1ns/100ps

module tb;
    // ====================================================================
    // Signals and counters
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wrData = 8'h00;
    logic wrEn = 1'b0;
    logic rdEn = 1'b0;
    logic [7:0] rdData_r;
    wire [1:0] keyOscIn;
    wire [1:0] refOscIn;
    logic [1:0] oscFreqSel_r;
    logic [1:0] keyOscRun_r;
    logic [1:0] refOscRun_r;
    touch_key_pkg::senseCfg_t [1:0] senseOut_r;
    logic [1:0][3:0] pinSenseEn_r;
    logic [1:0][9:0] refCapCode_r;
    logic irq_r;
    logic [15:0] held;
    logic [15:0] again;
    int fails = 0;
    int n_compared = 0;
    int n;
    // 25 MHz clock
    always #20 clk = ~clk;

    // ====================================================================
    // Design and pads; pad rates are unrelated to the clock on purpose
    touch_key_counter_config #(.NUM_MOD(2)) DUT (
        .clk(clk), .resetn(resetn), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
        .rdData_r(rdData_r), .keyOscIn(keyOscIn), .refOscIn(refOscIn),
        .oscFreqSel_r(oscFreqSel_r), .keyOscRun_r(keyOscRun_r), .refOscRun_r(refOscRun_r),
        .senseOut_r(senseOut_r), .pinSenseEn_r(pinSenseEn_r), .refCapCode_r(refCapCode_r),
        .irq_r(irq_r));
    touch_pad_osc #(.HALF_NS(53)) keyPad[1:0] (.run(keyOscRun_r), .osc(keyOscIn));
    touch_pad_osc #(.HALF_NS(97)) refPad[1:0] (.run(refOscRun_r), .osc(refOscIn));

    // ====================================================================
    // Bus tasks and compare
    function automatic logic [7:0] ma(input int m, input logic [7:0] o);
        return 8'(touch_key_pkg::MOD_BASE + touch_key_pkg::MOD_STRIDE * m + o);
    endfunction

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wrEn <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge clk);
        wrEn <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rdEn <= 1'b1;
        addr <= a;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        d = rdData_r;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask

    // No latch on the pair, so it is read only while counting is stopped
    task automatic rd16(input logic [7:0] a, output logic [15:0] d);
        rd(a, d[7:0]);
        rd(8'(a + 1), d[15:8]);
    endtask

    task automatic settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic wait_irq(output int cnt);
        cnt = 0;
        while (irq_r !== 1'b1)
        begin
            @(posedge clk);
            #1;
            cnt++;
            if (cnt > 3000)
            begin
                fails++;
                report_and_stop();
            end
        end
    endtask

    task automatic report_and_stop;
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ====================================================================
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        rdc(touch_key_pkg::OFF_OSC_FREQ, 8'h03);
        rd16(touch_key_pkg::OFF_CAL_LOW, held);
        check(held, 16'h0000);
        for (int m = 0; m < 2; m++)
            for (int o = 0; o < 6; o++)
                rdc(ma(m, 8'(o)), 8'h00);
        for (int f = 0; f < 4; f++)
        begin
            wr(touch_key_pkg::OFF_OSC_FREQ, 8'(8'hFC | f));
            settle();
            check(16'(oscFreqSel_r), 16'(f));
            rdc(touch_key_pkg::OFF_OSC_FREQ, 8'(f));
        end
        // Per-module controls: reserved bits, capacitor code, mux, doubling and hopping
        for (int m = 0; m < 2; m++)
        begin
            wr(ma(m, touch_key_pkg::MOFF_SENSE), 8'hFF);
            rdc(ma(m, touch_key_pkg::MOFF_SENSE), 8'hEF);
            wr(ma(m, touch_key_pkg::MOFF_ENABLE), 8'hFF);
            rdc(ma(m, touch_key_pkg::MOFF_ENABLE), 8'hBF);
            check(16'(pinSenseEn_r[m]), 16'h000F);
            wr(ma(m, touch_key_pkg::MOFF_CAP_LOW), 8'h5A);
            wr(ma(m, touch_key_pkg::MOFF_CAP_HIGH), 8'hFE);
            rdc(ma(m, touch_key_pkg::MOFF_CAP_HIGH), 8'h02);
            check(16'(refCapCode_r[m]), 16'h025A);
            for (int k = 0; k < 8; k++)
            begin
                wr(ma(m, touch_key_pkg::MOFF_SENSE), 8'({k[1:0], k[0], 2'b00, k[2:0]}));
                settle();
                check(16'(senseOut_r[m]), 16'({k[1:0], k[0], 1'b0, k[2:0]}));
            end
            wr(ma(m, touch_key_pkg::MOFF_SENSE), 8'h08);
            settle();
            check(16'(senseOut_r[m].hopCtrlSource && senseOut_r[m].hopFreqSel != 3'h0),
                16'h0001);
        end
        // Measurements: slot clock from system clock / 4, then from reference pad
        wr(touch_key_pkg::OFF_PRELOAD, 8'hFE);
        wr(touch_key_pkg::OFF_IRQ_EN, 8'h01);
        wr(ma(1, touch_key_pkg::MOFF_ENABLE), 8'h10);
        for (int s = 1; s >= 0; s--)
        begin
            wr(ma(0, touch_key_pkg::MOFF_ENABLE), s ? 8'hBF : 8'h3F);
            wr(touch_key_pkg::OFF_SLOT_CTRL, 8'h00);
            wr(touch_key_pkg::OFF_IRQ_CLR, 8'h07);
            wr(touch_key_pkg::OFF_SLOT_CTRL, 8'h20);
            settle();
            check(16'({keyOscRun_r, refOscRun_r}), 16'h000D);
            wait_irq(n);
            check(16'(s ? (n >= 248 && n <= 270) : (n > 280)), 16'h0001);
            settle();
            check(16'({keyOscRun_r, refOscRun_r}), 16'h0000);
            rdc(touch_key_pkg::OFF_SLOT_CTRL, 8'h60);
            rdc(touch_key_pkg::OFF_IRQ_STAT, 8'h01);
        end
        // Counters hold after overflow
        for (int p = 0; p < 2; p++)
        begin
            rd16(p ? ma(0, touch_key_pkg::MOFF_CF_LOW) : touch_key_pkg::OFF_CAL_LOW, held);
            check(16'(held != 16'h0000), 16'h0001);
            repeat (40) @(posedge clk);
            rd16(p ? ma(0, touch_key_pkg::MOFF_CF_LOW) : touch_key_pkg::OFF_CAL_LOW, again);
            check(again, held);
        end
        // Interrupt masked, unmasked and cleared
        wr(touch_key_pkg::OFF_IRQ_EN, 8'h00);
        settle();
        check(16'(irq_r), 16'h0000);
        wr(touch_key_pkg::OFF_IRQ_EN, 8'h01);
        settle();
        check(16'(irq_r), 16'h0001);
        wr(touch_key_pkg::OFF_IRQ_CLR, 8'h01);
        settle();
        check(16'(irq_r), 16'h0000);
        rdc(touch_key_pkg::OFF_IRQ_STAT, 8'h00);
        // Stopping detection clears the counters; they ignore writes
        wr(touch_key_pkg::OFF_SLOT_CTRL, 8'h00);
        wr(touch_key_pkg::OFF_CAL_LOW, 8'h55);
        settle();
        rd16(touch_key_pkg::OFF_CAL_LOW, held);
        check(held, 16'h0000);
        rd16(ma(0, touch_key_pkg::MOFF_CF_LOW), held);
        check(held, 16'h0000);
        rdc(8'hFF, 8'h00);
        report_and_stop();
    end
endmodule
